// File: rtl/usart_clock_generation.sv
// clock generation for a serial transceiver: fractional rate
// generator, async oversampling ticks, master transfer clock output,
// slave transfer clock input and data change / sample edge selection.
// assumes settings are steady while a transfer runs and that the
// transfer clock pin is a separate clock net when driven from outside.
`default_nettype none
`include "usart_clk_cfg.svh"

module usart_clock_generation (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic XCK_IN,
  input wire logic ENABLE,
  input wire usart_clk_pkg::clk_mode_t MODE,
  input wire logic [`UCG_PERIOD_W-1:0] PERIOD_SETTING,
  input wire logic [`UCG_SCALE_W-1:0] SCALE_EXPONENT,
  input wire logic DOUBLE_SPEED_SELECT,
  input wire logic PIN_INVERT_SELECT,
  input wire logic CLOCK_PHASE_SELECT,
  output logic XCK_OUT,
  output logic XCK_OE_N,
  output logic SAMPLE_TICK,
  output logic BIT_TICK,
  output logic TX_CHANGE,
  output logic RX_SAMPLE,
  output logic [`UCG_OVS_W-1:0] SAMPLES_PER_BIT,
  output logic CLOCK_ACTIVE,
  output logic SLAVE_CLK_FAULT
);
  import usart_clk_pkg::*;

  // decide whether an edge of the transfer clock samples data;
  // leading edge is rising unless inverted, phase picks its role
  function automatic logic edge_samples(
    input logic is_rising,
    input logic invert,
    input logic phase
  );
    logic leading;
    leading = is_rising ^ invert;
    edge_samples = leading ^ phase;
  endfunction

  // mode decode
  logic is_async; // internal generator, oversampled
  logic is_master; // internal generator, clock driven out
  logic is_slave; // clock taken from the pin
  logic is_spi; // spi master variant of master
  logic phase_eff; // phase used for edge roles
  logic gen_run; // fractional generator enable
  logic gen_tick; // generator output tick
  logic [`UCG_SCALE_W-1:0] scale_lim; // scale clamped to range

  // master clock sequencer
  ck_state_t ck_state_q; // where the master clock stands
  ck_state_t ck_state_d; // next sequencer state
  logic xck_level_q; // driven pin level
  logic xck_level_d; // next pin level
  logic edge_now; // a master edge happens this cycle
  logic edge_rising; // that edge is rising

  // async oversampling
  logic [`UCG_OVS_W-1:0] ovs_limit; // samples per bit now
  logic [`UCG_OVS_W-1:0] ovs_q; // sample index within a bit

  // slave edges after the crossing
  logic s_rise; // pin rose, seen in reference domain
  logic s_fall; // pin fell, seen in reference domain

  // registered outputs
  logic sample_tick_q; // oversample tick
  logic bit_tick_q; // one per bit
  logic tx_change_q; // data may change now
  logic rx_sample_q; // data is sampled now
  logic oe_n_q; // pin drive enable, low drives
  logic active_q; // a clock source is running
  logic fault_q; // slave pin too fast to resolve
  logic [`UCG_OVS_W-1:0] spb_q; // samples per bit, held in a flop

  // which of the five sources is chosen
  always_comb begin
    is_async = ENABLE && (MODE == CLK_ASYNC);
    is_master = ENABLE && ((MODE == CLK_SYNC_MASTER) ||
                           (MODE == CLK_SPI_MASTER));
    is_slave = ENABLE && (MODE == CLK_SYNC_SLAVE);
    is_spi = (MODE == CLK_SPI_MASTER);
    // plain synchronous mode changes on the leading edge
    phase_eff = is_spi ? CLOCK_PHASE_SELECT : 1'b1;
    // the generator runs for async and for both master kinds
    gen_run = is_async || is_master;
  end

  // the scale field is held to -7..+7; period spans its full width
  always_comb begin
    scale_lim = SCALE_EXPONENT;
    if (SCALE_EXPONENT == 4'h8) begin
      // -8 lies outside the field's range and acts as -7
      scale_lim = `UCG_SCALE_MIN;
    end
  end

  // internal fractional generator, shared by async and master
  frac_baud_gen u_gen (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .run(gen_run),
    .half_mode(is_master),
    .period(PERIOD_SETTING),
    .scale(scale_lim),
    .tick(gen_tick)
  );

  // pin edges of the external clock, crossed into REF_CLK
  xck_edge_sync u_xck (
    .xck_clk(XCK_IN),
    .clk(REF_CLK),
    .rst_n(RST_N),
    .rise_evt(s_rise),
    .fall_evt(s_fall)
  );

  // samples per bit: sixteen normally, eight at double speed
  always_comb begin
    if (DOUBLE_SPEED_SELECT) begin
      ovs_limit = `UCG_OVS_DOUBLE;
    end else begin
      ovs_limit = `UCG_OVS_NORMAL;
    end
  end

  // sample index; wraps once per bit, giving the bit rate
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ovs_q <= '0;
    end else if (!is_async) begin
      // held at zero outside async modes
      ovs_q <= '0;
    end else if (gen_tick) begin
      if (ovs_q == ovs_limit - `UCG_OVS_W'(1)) begin
        // last sample of the bit wraps the index
        ovs_q <= '0;
      end else begin
        ovs_q <= ovs_q + `UCG_OVS_W'(1);
      end
    end
  end

  // samples per bit as a registered data output
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      spb_q <= `UCG_OVS_NORMAL;
    end else begin
      spb_q <= ovs_limit;
    end
  end

  // master sequencer: each generator tick is one half period
  always_comb begin
    ck_state_d = ck_state_q;
    xck_level_d = xck_level_q;
    edge_now = 1'b0;
    edge_rising = 1'b0;
    case (ck_state_q)
      CK_IDLE: begin
        // clock rests at its idle level, set by inversion
        xck_level_d = PIN_INVERT_SELECT;
        if (is_master && gen_tick) begin
          // leading edge leaves the idle level
          ck_state_d = CK_ACTIVE;
          xck_level_d = ~PIN_INVERT_SELECT;
          edge_now = 1'b1;
          edge_rising = ~PIN_INVERT_SELECT;
        end
      end
      CK_ACTIVE: begin
        // second half: trailing edge back to idle level
        if (gen_tick || !is_master) begin
          ck_state_d = is_master ? CK_RESTING : CK_IDLE;
          xck_level_d = PIN_INVERT_SELECT;
          edge_now = is_master;
          edge_rising = PIN_INVERT_SELECT;
        end
      end
      CK_RESTING: begin
        // first half of the next cycle, or stop when disabled
        if (!is_master) begin
          // disabled while resting: back to idle
          ck_state_d = CK_IDLE;
        end else if (gen_tick) begin
          ck_state_d = CK_ACTIVE;
          xck_level_d = ~PIN_INVERT_SELECT;
          edge_now = 1'b1;
          edge_rising = ~PIN_INVERT_SELECT;
        end
      end
      default: begin
        // unused code: recover to idle
        ck_state_d = CK_IDLE;
        xck_level_d = PIN_INVERT_SELECT;
      end
    endcase
  end

  // master sequencer state and pin level
  // idle level follows inversion from the first edge after reset
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ck_state_q <= CK_IDLE;
      xck_level_q <= `UCG_XCK_RESET;
    end else begin
      ck_state_q <= ck_state_d;
      xck_level_q <= xck_level_d;
    end
  end

  // pin direction: driven only as master, input as slave
  // registered, so the drive starts one cycle after the mode
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      oe_n_q <= `UCG_OE_N_RESET;
    end else begin
      oe_n_q <= ~is_master;
    end
  end

  // async ticks: every generator tick samples, wrap marks a bit
  // registered, so the strobe trails the generator by one cycle
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sample_tick_q <= 1'b0;
    end else begin
      sample_tick_q <= is_async && gen_tick;
    end
  end

  // sample strobe for master and slave clocks
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_sample_q <= 1'b0;
    end else if (is_master) begin
      // sample on the edge whose role is sampling
      rx_sample_q <= edge_now &&
        edge_samples(edge_rising, PIN_INVERT_SELECT, phase_eff);
    end else if (is_slave) begin
      // slave edges from the pin, same edge roles as sync master
      rx_sample_q <=
        (s_rise && edge_samples(1'b1, PIN_INVERT_SELECT, 1'b1)) ||
        (s_fall && edge_samples(1'b0, PIN_INVERT_SELECT, 1'b1));
    end else begin
      // no clock source, no strobe
      rx_sample_q <= 1'b0;
    end
  end

  // change strobe, on the edge opposite the sample
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_change_q <= 1'b0;
    end else if (is_master) begin
      // data changes on the other edge of each pair
      tx_change_q <= edge_now &&
        !edge_samples(edge_rising, PIN_INVERT_SELECT, phase_eff);
    end else if (is_slave) begin
      // rising pin edge changes data unless inverted
      tx_change_q <=
        (s_rise && !edge_samples(1'b1, PIN_INVERT_SELECT, 1'b1)) ||
        (s_fall && !edge_samples(1'b0, PIN_INVERT_SELECT, 1'b1));
    end else begin
      // no clock source, no strobe
      tx_change_q <= 1'b0;
    end
  end

  // one pulse per bit in async, master and slave modes
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bit_tick_q <= 1'b0;
    end else if (is_async) begin
      bit_tick_q <= gen_tick &&
        (ovs_q == ovs_limit - `UCG_OVS_W'(1));
    end else if (is_master) begin
      // a bit ends on each trailing edge
      bit_tick_q <= edge_now && (ck_state_q == CK_ACTIVE);
    end else if (is_slave) begin
      // a bit ends when the pin goes back to its idle level
      bit_tick_q <= PIN_INVERT_SELECT ? s_rise : s_fall;
    end else begin
      // no clock source, no bits
      bit_tick_q <= 1'b0;
    end
  end

  // status: a clock source is running
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      active_q <= 1'b0;
    end else begin
      active_q <= gen_run || is_slave;
    end
  end

  // status: both pin edges in one reference cycle, phases too short
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= is_slave && s_rise && s_fall;
    end
  end

  // output assignments
  assign XCK_OUT = xck_level_q;
  assign XCK_OE_N = oe_n_q;
  assign SAMPLE_TICK = sample_tick_q;
  assign BIT_TICK = bit_tick_q;
  assign TX_CHANGE = tx_change_q;
  assign RX_SAMPLE = rx_sample_q;
  assign SAMPLES_PER_BIT = spb_q;
  assign CLOCK_ACTIVE = active_q;
  assign SLAVE_CLK_FAULT = fault_q;

endmodule

`default_nettype wire

// File: rtl/usart_clk_cfg.svh
// constants for the serial clock generation block: widths, field
// limits, oversampling figures and the reference clock rate.
// assumes it is included by bare name from rtl/ and test/ files.
`ifndef USART_CLK_CFG_SVH
`define USART_CLK_CFG_SVH

// period setting: twelve-bit unsigned, 0 to 4095
`define UCG_PERIOD_W 12
`define UCG_PERIOD_MAX 12'hfff
// scale exponent: four-bit two's complement, -7 to +7
`define UCG_SCALE_W 4
`define UCG_SCALE_MAX 4'h7
`define UCG_SCALE_MIN 4'h9
// field position of the scale sign bit
`define UCG_SCALE_SIGN 3
// down counter wide enough for 4096 * 128 cycles
`define UCG_COUNT_W 20
// fraction accumulator for scale magnitudes up to 7
`define UCG_ACC_W 7
`define UCG_SUM_W 13
// samples per bit in asynchronous modes
`define UCG_OVS_W 5
`define UCG_OVS_NORMAL 5'h10
`define UCG_OVS_DOUBLE 5'h08
// reference clock period in ns and slave pin limit divisor
`define UCG_REF_PERIOD_NS 40
`define UCG_SLAVE_DIV 4
// reset values of the clock pin
`define UCG_XCK_RESET 1'b0
`define UCG_OE_N_RESET 1'b1

`endif

// File: rtl/usart_clk_pkg.sv
// types shared by the serial clock generation block.
// assumes usart_clk_cfg.svh sits beside it under rtl/.
`default_nettype none

package usart_clk_pkg;

  // clock source; async double speed is async plus the double bit
  typedef enum logic [2:0] {
    CLK_ASYNC = 3'b000,
    CLK_SYNC_MASTER = 3'b001,
    CLK_SYNC_SLAVE = 3'b010,
    CLK_SPI_MASTER = 3'b011,
    CLK_OFF = 3'b100
  } clk_mode_t;

  // master transfer clock sequencer
  typedef enum logic [1:0] {
    CK_IDLE = 2'b00,
    CK_ACTIVE = 2'b01,
    CK_RESTING = 2'b10
  } ck_state_t;

endpackage

`default_nettype wire

// File: rtl/frac_baud_gen.sv
// fractional period generator: one-cycle tick at a programmable rate.
// assumes inputs are steady on REF_CLK; a change takes effect at the
// next reload of the down counter.
`default_nettype none
`include "usart_clk_cfg.svh"

module frac_baud_gen (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic half_mode,
  input wire logic [`UCG_PERIOD_W-1:0] period,
  input wire logic [`UCG_SCALE_W-1:0] scale,
  output logic tick
);

  logic [`UCG_COUNT_W-1:0] count_q; // cycles left before the tick
  logic [`UCG_ACC_W-1:0] acc_q; // fraction carried between ticks
  logic [`UCG_COUNT_W-1:0] load_d; // reload value at each tick
  logic [`UCG_ACC_W-1:0] acc_d; // next fraction
  logic [2:0] mag; // magnitude of a negative scale
  logic [`UCG_SUM_W-1:0] sum; // fraction plus period
  logic [`UCG_SUM_W-1:0] mask; // low bits kept as fraction

  // reload value per mode and scale sign
  always_comb begin
    mag = 3'(~scale[2:0] + 3'h1);
    if (mag == 3'h0) begin
      mag = 3'h7; // -8 is out of range, held at -7
    end
    sum = {1'b0, period} + {{(`UCG_SUM_W-`UCG_ACC_W){1'b0}}, acc_q};
    mask = (`UCG_SUM_W'(1) << mag) - `UCG_SUM_W'(1);
    acc_d = acc_q;
    if (half_mode) begin
      // half period of the master clock, scale ignored
      load_d = `UCG_COUNT_W'(period);
    end else if (!scale[`UCG_SCALE_SIGN]) begin
      // (period+1) * 2^scale cycles per tick
      load_d = ((`UCG_COUNT_W'(period) + `UCG_COUNT_W'(1)) << scale[2:0])
               - `UCG_COUNT_W'(1);
    end else begin
      // 1 + period/2^mag cycles on average by stretching
      load_d = `UCG_COUNT_W'(sum >> mag);
      acc_d = `UCG_ACC_W'(sum & mask);
    end
  end

  // down counter with reload and fraction update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
      acc_q <= '0;
    end else if (!run) begin
      count_q <= '0;
      acc_q <= '0;
    end else if (count_q == '0) begin
      count_q <= load_d;
      acc_q <= acc_d;
    end else begin
      count_q <= count_q - `UCG_COUNT_W'(1);
    end
  end

  // tick in the cycle the counter runs out
  assign tick = run && (count_q == '0);

endmodule

`default_nettype wire

// File: rtl/xck_edge_sync.sv
// link side of the slave transfer clock: toggles on each pin edge in
// the pin's own domain, carried into REF_CLK by two flip-flops each.
// assumes the pin clock may stop between frames; events are edges.
`default_nettype none

module xck_edge_sync (
  input wire logic xck_clk,
  input wire logic clk,
  input wire logic rst_n,
  output logic rise_evt,
  output logic fall_evt
);

  logic rise_tgl_q; // flips on each rising pin edge
  logic fall_tgl_q; // flips on each falling pin edge
  logic [2:0] rise_sync_q; // two-stage sync plus history
  logic [2:0] fall_sync_q; // two-stage sync plus history

  // link domain: rising edge toggle
  always_ff @(posedge xck_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_tgl_q <= 1'b0;
    end else begin
      rise_tgl_q <= ~rise_tgl_q;
    end
  end

  // link domain: falling edge toggle
  always_ff @(negedge xck_clk or negedge rst_n) begin
    if (!rst_n) begin
      fall_tgl_q <= 1'b0;
    end else begin
      fall_tgl_q <= ~fall_tgl_q;
    end
  end

  // reference domain: synchronise both toggles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_sync_q <= '0;
      fall_sync_q <= '0;
    end else begin
      rise_sync_q <= {rise_sync_q[1:0], rise_tgl_q};
      fall_sync_q <= {fall_sync_q[1:0], fall_tgl_q};
    end
  end

  // an event is a change past the second stage only
  assign rise_evt = rise_sync_q[2] ^ rise_sync_q[1];
  assign fall_evt = fall_sync_q[2] ^ fall_sync_q[1];

endmodule

`default_nettype wire

// File: test/usart_clock_generation_asserts.sv
// checker for the clock generation block, bound to its top module.
// assumes settings stay steady while ENABLE is high.
`default_nettype none
`include "usart_clk_cfg.svh"

module usart_clock_generation_asserts (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic XCK_IN,
  input wire logic ENABLE,
  input wire usart_clk_pkg::clk_mode_t MODE,
  input wire logic [`UCG_PERIOD_W-1:0] PERIOD_SETTING,
  input wire logic [`UCG_SCALE_W-1:0] SCALE_EXPONENT,
  input wire logic DOUBLE_SPEED_SELECT,
  input wire logic PIN_INVERT_SELECT,
  input wire logic CLOCK_PHASE_SELECT,
  input wire logic XCK_OUT,
  input wire logic XCK_OE_N,
  input wire logic BIT_TICK,
  input wire logic TX_CHANGE,
  input wire logic RX_SAMPLE,
  input wire logic [`UCG_OVS_W-1:0] SAMPLES_PER_BIT
);
  import usart_clk_pkg::*;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  logic mst; // a master mode runs
  logic asy; // async run with zero scale
  logic slv; // slave mode runs
  logic [19:0] lim; // last cycle count of one bit
  logic [19:0] cnt_q; // cycles since the last bit tick
  logic ok_q; // one bit tick seen under steady settings
  assign mst = ENABLE && (MODE == CLK_SYNC_MASTER || MODE == CLK_SPI_MASTER);
  assign asy = ENABLE && MODE == CLK_ASYNC && SCALE_EXPONENT == 4'h0;
  assign slv = ENABLE && MODE == CLK_SYNC_SLAVE;
  assign lim = (20'(PERIOD_SETTING) + 20'h1) *
    (DOUBLE_SPEED_SELECT ? 20'h8 : 20'h10) - 20'h1;
  // bit tick interval counter
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_q <= 20'h0;
      ok_q <= 1'b0;
    end else begin
      cnt_q <= BIT_TICK ? 20'h0 : cnt_q + 20'h1;
      ok_q <= asy && (BIT_TICK || ok_q);
    end
  end
  bit_period_a: assert property (ok_q && asy |->
    (BIT_TICK ? cnt_q == lim : cnt_q < lim)) else $error("bit period");
  samples_a: assert property ($past(RST_N) |-> SAMPLES_PER_BIT ==
    ($past(DOUBLE_SPEED_SELECT) ? 5'h08 : 5'h10)) else $error("samples");
  oe_master_a: assert property (mst [*2] |-> !XCK_OE_N)
    else $error("pin not driven");
  oe_slave_a: assert property (slv [*2] |-> XCK_OE_N)
    else $error("pin driven in slave");
  edges_apart_a: assert property (!(TX_CHANGE && RX_SAMPLE))
    else $error("change and sample together");
  sync_edge_a: assert property (ENABLE && MODE == CLK_SYNC_MASTER &&
    (TX_CHANGE || RX_SAMPLE) |-> XCK_OUT == (TX_CHANGE ^ PIN_INVERT_SELECT))
    else $error("sync edge");
  spi_edge_a: assert property (ENABLE && MODE == CLK_SPI_MASTER &&
    RX_SAMPLE |-> XCK_OUT == !(PIN_INVERT_SELECT ^ CLOCK_PHASE_SELECT))
    else $error("spi sample edge");
  fast_toggle_a: assert property (mst && PERIOD_SETTING == 12'h0 [*4]
    |-> XCK_OUT != $past(XCK_OUT)) else $error("master rate");
  slave_follow_a: assert property (slv && $rose(XCK_IN) |->
    ##[1:6] (PIN_INVERT_SELECT ? RX_SAMPLE : TX_CHANGE))
    else $error("slave edge lost");
  cover property (ok_q && asy && BIT_TICK && DOUBLE_SPEED_SELECT);
  cover property (ENABLE && MODE == CLK_SPI_MASTER && RX_SAMPLE);
  cover property (slv && TX_CHANGE);
endmodule

bind usart_clock_generation usart_clock_generation_asserts
  usart_clock_generation_asserts_i (.REF_CLK, .RST_N, .XCK_IN, .ENABLE,
  .MODE, .PERIOD_SETTING, .SCALE_EXPONENT, .DOUBLE_SPEED_SELECT,
  .PIN_INVERT_SELECT, .CLOCK_PHASE_SELECT, .XCK_OUT, .XCK_OE_N,
  .BIT_TICK, .TX_CHANGE, .RX_SAMPLE, .SAMPLES_PER_BIT);

`default_nettype wire

// File: test/xck_peer_model.sv
// far side: a synchronous peer that drives the transfer clock pin.
// assumes link_clk is the bench's 15 ns clock; a frame starts on go.
`default_nettype none

module xck_peer_model (
  input wire logic link_clk,
  input wire logic go,
  input wire logic inv,
  output logic xck
);
  timeunit 1ns;
  timeprecision 100ps;
  logic busy_q; // frame in progress
  logic [2:0] div_q; // link cycles within one phase
  logic [3:0] edge_q; // clock edges sent so far
  initial begin
    xck = 1'b0;
    busy_q = 1'b0;
  end
  // pin rests at idle level, eight link cycles per phase in a frame
  always @(posedge link_clk) begin
    if (!busy_q) begin
      xck <= inv;
      busy_q <= go;
      div_q <= 3'h0;
      edge_q <= 4'h0;
    end else begin
      div_q <= div_q + 3'h1;
      if (div_q == 3'h7) begin
        xck <= ~xck;
        edge_q <= edge_q + 4'h1;
        busy_q <= edge_q != 4'hf;
      end
    end
  end
endmodule

`default_nettype wire

// File: test/usart_clock_generation_tb_top.sv
// self-checking bench for the clock generation block.
// assumes design, checker and peer model are compiled before it.
`default_nettype none
`include "usart_clk_cfg.svh"

module usart_clock_generation_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import usart_clk_pkg::*;
  typedef struct {
    clk_mode_t md;
    logic ds;
    logic [11:0] p;
    logic [3:0] s;
    int sel;
    int exp;
  } row_t;
  logic ref_clk, link_clk, rst_n, enable, ds, inv, ph, go; // stimulus
  logic xck_in, xck_out, xck_oe_n, samp, bitt, txc, rxs, act, flt; // pins
  logic [11:0] period; // period setting
  logic [3:0] scale; // scale exponent
  logic [4:0] spb; // samples per bit
  clk_mode_t mode; // clock source
  int c [6]; // samples, bits, rises, changes, samples taken, faults
  int mismatches = 0;
  int n_tests = 0;
  // rate rows: counter index and count over 480 cycles
  row_t rows [11] = '{
    '{CLK_ASYNC, 1'b0, 12'h0, 4'h0, 0, 480},
    '{CLK_ASYNC, 1'b0, 12'h0, 4'h0, 1, 30},
    '{CLK_ASYNC, 1'b1, 12'h0, 4'h0, 1, 60},
    '{CLK_ASYNC, 1'b0, 12'h4, 4'h0, 0, 96},
    '{CLK_ASYNC, 1'b0, 12'h1, 4'h2, 0, 60},
    '{CLK_ASYNC, 1'b0, 12'h1, 4'hf, 0, 320},
    '{CLK_ASYNC, 1'b1, 12'h80, 4'h9, 0, 240},
    '{CLK_ASYNC, 1'b0, 12'hfff, 4'h0, 0, 0},
    '{CLK_ASYNC, 1'b0, 12'h7f, 4'h0, 0, 4},
    '{CLK_SYNC_MASTER, 1'b0, 12'h0, 4'h0, 2, 240},
    '{CLK_SPI_MASTER, 1'b0, 12'h2, 4'h5, 2, 80}
  };

  always #20 ref_clk = ~ref_clk;
  // link clock, phase unrelated to ref_clk
  initial begin
    link_clk = 1'b0;
    #3.1;
    forever #7.5 link_clk = ~link_clk;
  end

  xck_peer_model xck_peer_model_i (.link_clk(link_clk), .go(go),
    .inv(inv), .xck(xck_in));
  usart_clock_generation usart_clock_generation_i (.REF_CLK(ref_clk),
    .RST_N(rst_n), .XCK_IN(xck_in), .ENABLE(enable), .MODE(mode),
    .PERIOD_SETTING(period), .SCALE_EXPONENT(scale),
    .DOUBLE_SPEED_SELECT(ds), .PIN_INVERT_SELECT(inv),
    .CLOCK_PHASE_SELECT(ph), .XCK_OUT(xck_out), .XCK_OE_N(xck_oe_n),
    .SAMPLE_TICK(samp), .BIT_TICK(bitt), .TX_CHANGE(txc),
    .RX_SAMPLE(rxs), .SAMPLES_PER_BIT(spb), .CLOCK_ACTIVE(act),
    .SLAVE_CLK_FAULT(flt));

  // step past n rising edges, then settle
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // compare and count
  task automatic chk(input string nm, input logic [15:0] got,
    input logic [15:0] want);
    n_tests++;
    if (got !== want) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", nm, want, got);
    end
  endtask

  // count pulse outputs over n cycles
  task automatic run(input int n);
    logic prev;
    c = '{default: 0};
    prev = xck_out;
    repeat (n) begin
      cyc(1);
      c[0] += int'(samp === 1'b1);
      c[1] += int'(bitt === 1'b1);
      c[2] += int'(xck_out === 1'b1 && prev === 1'b0);
      c[3] += int'(txc === 1'b1);
      c[4] += int'(rxs === 1'b1);
      c[5] += int'(flt === 1'b1);
      prev = xck_out;
    end
  endtask

  // count within two of the expected one passes as expected
  function automatic logic [15:0] near(input int v, input int e);
    return (v >= e - 2 && v <= e + 2) ? 16'(e) : 16'(v);
  endfunction

  // stop the clocks so that settings may change safely
  task automatic halt;
    enable = 1'b0;
    cyc(3);
  endtask

  // set a mode, restart and let it settle
  task automatic start(input clk_mode_t m);
    mode = m;
    cyc(6);
    enable = 1'b1;
    cyc(4);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #600000;
    mismatches++;
    end_sim();
  end

  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    {enable, ds, inv, ph, go} = 5'h0;
    mode = CLK_OFF;
    period = 12'h0;
    scale = 4'h0;
    cyc(2);
    rst_n = 1'b1;
    // rate table; settings only change while stopped
    foreach (rows[i]) begin
      halt();
      {ds, period, scale} = {rows[i].ds, rows[i].p, rows[i].s};
      start(rows[i].md);
      run(480);
      chk("count", near(c[rows[i].sel], rows[i].exp), 16'(rows[i].exp));
      chk("spb", 16'(spb), rows[i].ds ? 16'h8 : 16'h10);
      $display("row %0d done", i);
    end
    // spi modes 0 to 3
    for (int m = 0; m < 4; m++) begin
      halt();
      {inv, ph} = 2'(m);
      period = 12'h1;
      start(CLK_SPI_MASTER);
      run(40);
      chk("oe_n", 16'(xck_oe_n), 16'h0);
      chk("rx", near(c[4], 10), 16'd10);
      chk("tx", near(c[3], 10), 16'd10);
      chk("bit", near(c[1], 10), 16'd10);
      $display("spi mode %0d done", m);
    end
    // slave frames of eight bits, both pin polarities
    for (int v = 0; v < 2; v++) begin
      halt();
      inv = v[0];
      start(CLK_SYNC_SLAVE);
      go = 1'b1;
      cyc(2);
      go = 1'b0;
      run(70);
      chk("oe_n", 16'(xck_oe_n), 16'h1);
      chk("tx", 16'(c[3]), 16'd8);
      chk("rx", 16'(c[4]), 16'd8);
      chk("bit", 16'(c[1]), 16'd8);
      chk("fault", 16'(c[5]), 16'h0);
      $display("slave %0d done", v);
    end
    // reset in mid-run
    halt();
    inv = 1'b0;
    start(CLK_SYNC_MASTER);
    rst_n = 1'b0;
    #5;
    chk("oe_n", 16'(xck_oe_n), 16'h1);
    chk("xck", 16'(xck_out), 16'h0);
    chk("active", 16'(act), 16'h0);
    cyc(2);
    rst_n = 1'b1;
    cyc(6);
    chk("active", 16'(act), 16'h1);
    $display("reset test done");
    end_sim();
  end
endmodule

`default_nettype wire
